// >>> rtl/dfpa_arbiter.sv
// Display FIFO priority arbiter with its AXI4-Lite register slave.
// How it works
// - Seven sources (graphics, panel read one, video one, video two, panel write, capture, panel read two) each have a rank field.
// - A source whose rank field is zero is never granted.
// - Among pending enabled sources the smallest nonzero code wins, 1 highest and 7 lowest.
// - Panel read two rank sits in bits 26:24 and resets to 7.
// - Capture window rank sits in bits 22:20 and resets to 2.
// - Panel write rank sits in bits 18:16 and resets to 1.
// - Video window two rank sits in bits 14:12 and resets to 6.
// - Video window one rank sits in bits 10:8 and resets to 5.
// - Panel read one rank sits in bits 6:4 and resets to 4.
// - Graphics rank sits in bits 2:0 and resets to 3, giving 07216543h for the register.
// - Graphics and video FIFOs request once their empty count reaches a selectable level of 2 to 12, default 6.
`timescale 1ns/100ps
`default_nettype none
`include "dfpa_cfg.svh"

module dfpa_arbiter
   import dfpa_pkg::*;
#(
   parameter int SOURCES = 7,
   parameter int COUNT_W = 5
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [COUNT_W-1:0] graphics_empty,
   input wire logic [COUNT_W-1:0] video_one_empty,
   input wire logic [COUNT_W-1:0] video_two_empty,
   input wire logic panel_read_one_req,
   input wire logic panel_write_req,
   input wire logic capture_req,
   input wire logic panel_read_two_req,
   input wire logic xfer_done,
   output logic [SOURCES-1:0] grant,
   output logic grant_valid
);

   // =====================================================================
   // Registers
   // =====================================================================
   logic [31:0] fifo_priority_select;
   logic [31:0] level_select;
   logic [31:0] next_prio;
   logic [31:0] next_level;
   logic [7:0] aw_addr;
   logic aw_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_held;
   logic do_write;
   logic [SOURCES-1:0] pending;
   logic [SOURCES-1:0] served;
   logic [SOURCES*3-1:0] codes;
   logic [2:0] grant_index;
   dfpa_grant_s pick;
   logic [SOURCES-1:0] zero_mask;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      merge = res & mask;
   endfunction : merge

   // =====================================================================
   // Write channel
   // =====================================================================
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         s_axi_awready <= 1'b0;
      end else if (do_write) begin
         aw_held <= 1'b0;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_wready <= 1'b0;
      end else if (do_write) begin
         w_held <= 1'b0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_held && !s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= DFPA_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         // The status word is read-only, so a write to it answers SLVERR.
         s_axi_bresp <= (aw_addr[7:2] == 6'(`DFPA_PRIO_OFFSET >> 2) || aw_addr[7:2] == 6'(`DFPA_LEVEL_OFFSET >> 2))
                        ? DFPA_RESP_OKAY : DFPA_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_comb begin
      next_prio = fifo_priority_select;
      next_level = level_select;
      if (do_write && aw_addr[7:2] == 6'(`DFPA_PRIO_OFFSET >> 2)) begin
         next_prio = merge(fifo_priority_select, w_data, w_strb, `DFPA_PRIO_MASK);
      end
      if (do_write && aw_addr[7:2] == 6'(`DFPA_LEVEL_OFFSET >> 2)) begin
         next_level = merge(level_select, w_data, w_strb, `DFPA_LEVEL_MASK);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fifo_priority_select <= `DFPA_PRIO_RESET;
         level_select <= `DFPA_LEVEL_RESET;
      end else begin
         fifo_priority_select <= next_prio;
         level_select <= next_level;
      end
   end

   // =====================================================================
   // Read channel
   // =====================================================================
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= DFPA_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= DFPA_RESP_OKAY;
         case (s_axi_araddr[7:2])
            6'(`DFPA_PRIO_OFFSET >> 2): s_axi_rdata <= fifo_priority_select;
            6'(`DFPA_LEVEL_OFFSET >> 2): s_axi_rdata <= level_select;
            6'(`DFPA_STATUS_OFFSET >> 2): s_axi_rdata <= {20'h00000, 4'(grant_index), grant_valid,
                                                          pending};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= DFPA_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // =====================================================================
   // Requests and arbitration
   // =====================================================================
   dfpa_level_detect #(.COUNT_W(COUNT_W)) u_graphics_level (
      .level_sel(level_select[2:0]),
      .empty_count(graphics_empty),
      .request(pending[0])
   );

   dfpa_level_detect #(.COUNT_W(COUNT_W)) u_video_one_level (
      .level_sel(level_select[6:4]),
      .empty_count(video_one_empty),
      .request(pending[2])
   );

   dfpa_level_detect #(.COUNT_W(COUNT_W)) u_video_two_level (
      .level_sel(level_select[10:8]),
      .empty_count(video_two_empty),
      .request(pending[3])
   );

   assign pending[1] = panel_read_one_req;
   assign pending[4] = panel_write_req;
   assign pending[5] = capture_req;
   assign pending[6] = panel_read_two_req;

   // Field i of the register feeds source i in the picker's index order.
   for (genvar g = 0; g < SOURCES; g++) begin : g_codes
      assign codes[g*3 +: 3] = fifo_priority_select[g*`DFPA_FIELD_STRIDE +: 3];
      // Disabled sources are decoded apart from the picker so the checks below stay independent of it.
      assign zero_mask[g] = (fifo_priority_select[g*`DFPA_FIELD_STRIDE +: 3] == 3'h0);
   end

   dfpa_pick #(.SOURCES(SOURCES)) u_pick (
      .pending(pending),
      .codes(codes),
      .pick(pick)
   );

   // A grant is held until the memory side reports its transfer done, so a
   // rank change never cuts a transfer short; the new ranks apply to the next pick.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         grant_valid <= 1'b0;
         grant_index <= 3'h0;
         grant <= '0;
      end else if (grant_valid) begin
         if (xfer_done) begin
            grant_valid <= 1'b0;
            grant <= '0;
         end
      end else if (pick.valid) begin
         grant_valid <= 1'b1;
         grant_index <= pick.index;
         grant <= served;
      end
   end

   always_comb begin
      served = '0;
      served[pick.index] = 1'b1;
   end

   // =====================================================================
   // Checks
   // =====================================================================
   disabled_never_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(grant_valid) |-> ($past(zero_mask) & grant) == '0)
      else $error("Granted a source whose rank is zero.");

   grant_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      grant_valid && !xfer_done |=> grant_valid && $stable(grant))
      else $error("Grant changed before the transfer finished.");

   reset_value_a: assert property (@(posedge aclk)
      !aresetn |=> fifo_priority_select == 32'h07216543)
      else $error("Priority register reset value wrong.");

   panel_write_top_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !$past(aresetn) && aresetn |-> fifo_priority_select[18:16] == 3'h1)
      else $error("Panel write rank reset value wrong.");

   capture_rank_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !$past(aresetn) && aresetn |-> fifo_priority_select[22:20] == 3'h2)
      else $error("Capture rank reset value wrong.");

   read_two_rank_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !$past(aresetn) && aresetn |-> fifo_priority_select[26:24] == 3'h7)
      else $error("Panel read two rank reset value wrong.");

   video_ranks_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !$past(aresetn) && aresetn |-> fifo_priority_select[14:12] == 3'h6 && fifo_priority_select[10:8] == 3'h5)
      else $error("Video window rank reset values wrong.");

   read_one_rank_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !$past(aresetn) && aresetn |-> fifo_priority_select[6:4] == 3'h4)
      else $error("Panel read one rank reset value wrong.");

   best_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !grant_valid && pending[4] && codes[14:12] == 3'h1 |=> grant_valid && grant_index <= 3'h4)
      else $error("A rank-one source was passed over.");

   tie_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !grant_valid && pending[0] && pending[1] && codes[2:0] == 3'h1 && codes[5:3] == 3'h1
      |=> grant_index == 3'h0)
      else $error("Tie not resolved toward graphics.");

   graphics_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
      level_select[2:0] == 3'h4 && graphics_empty == COUNT_W'(5) |-> !pending[0])
      else $error("Graphics request raised below the default level.");

   fixed_wiring_a: assert property (@(posedge aclk) disable iff (!aresetn)
      codes[20:18] == fifo_priority_select[26:24] && codes[2:0] == fifo_priority_select[2:0])
      else $error("Rank fields not routed to their sources.");

   grant_onehot_a: assert property (@(posedge aclk) disable iff (!aresetn)
      grant_valid ? $onehot(grant) : grant == '0)
      else $error("Grant vector not one-hot while valid or not clear while idle.");

   grant_ends_a: assert property (@(posedge aclk) disable iff (!aresetn)
      grant_valid && xfer_done |=> !grant_valid && grant == '0)
      else $error("Grant outlived the end of its transfer.");

   grant_pending_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(grant_valid) |-> ($past(pending) & grant) != '0)
      else $error("Grant given to a source that was not requesting.");

   reserved_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (fifo_priority_select & ~`DFPA_PRIO_MASK) == 32'h00000000)
      else $error("Reserved rank register bits are set.");

   rank_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && aw_addr[7:2] == 6'(`DFPA_PRIO_OFFSET >> 2) && w_strb == 4'hF
      |=> fifo_priority_select == ($past(w_data) & `DFPA_PRIO_MASK))
      else $error("Full-word rank write did not land.");

   write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write |=> s_axi_bvalid)
      else $error("Write response did not follow the write.");

   read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("Read data did not follow its address.");

endmodule : dfpa_arbiter
`default_nettype wire

// >>> rtl/dfpa_cfg.svh
// Register offsets, field positions, reset values and write masks of the display FIFO arbiter.
`ifndef DFPA_CFG_SVH
`define DFPA_CFG_SVH

`define DFPA_PRIO_OFFSET 8'h54
`define DFPA_LEVEL_OFFSET 8'h58
`define DFPA_STATUS_OFFSET 8'h5C
`define DFPA_PRIO_RESET 32'h07216543
`define DFPA_PRIO_MASK 32'h07777777
`define DFPA_LEVEL_RESET 32'h00000444
`define DFPA_LEVEL_MASK 32'h00000777
`define DFPA_GRAPHICS_LSB 0
`define DFPA_PANEL_READ_ONE_LSB 4
`define DFPA_VIDEO_ONE_LSB 8
`define DFPA_VIDEO_TWO_LSB 12
`define DFPA_PANEL_WRITE_LSB 16
`define DFPA_CAPTURE_LSB 20
`define DFPA_PANEL_READ_TWO_LSB 24
`define DFPA_FIELD_STRIDE 4

`endif

// >>> rtl/dfpa_pkg.sv
// Types shared by the display FIFO arbiter files.
package dfpa_pkg;

   typedef logic [2:0] dfpa_code_t;

   typedef struct packed {
      logic [2:0] index;
      logic valid;
   } dfpa_grant_s;

   typedef enum logic [1:0] {
      DFPA_RESP_OKAY = 2'h0,
      DFPA_RESP_SLVERR = 2'h2
   } dfpa_resp_e;

endpackage : dfpa_pkg

// >>> rtl/dfpa_level_detect.sv
// Empty-entry threshold detector that turns a FIFO fill level into a memory request.
`timescale 1ns/100ps
`default_nettype none

module dfpa_level_detect
   import dfpa_pkg::*;
#(
   parameter int COUNT_W = 5
) (
   input wire logic [2:0] level_sel,
   input wire logic [COUNT_W-1:0] empty_count,
   output logic request
);

   // =====================================================================
   // Threshold table
   // =====================================================================
   function automatic logic [COUNT_W-1:0] threshold(input logic [2:0] sel);
      case (sel)
         3'h0: threshold = COUNT_W'(2);
         3'h1: threshold = COUNT_W'(3);
         3'h2: threshold = COUNT_W'(4);
         3'h3: threshold = COUNT_W'(5);
         3'h4: threshold = COUNT_W'(6);
         3'h5: threshold = COUNT_W'(8);
         3'h6: threshold = COUNT_W'(10);
         default: threshold = COUNT_W'(12);
      endcase
   endfunction : threshold

   assign request = (empty_count >= threshold(level_sel));

endmodule : dfpa_level_detect
`default_nettype wire

// >>> rtl/dfpa_pick.sv
// Combinational priority picker: smallest nonzero code wins, lowest index breaks ties.
`timescale 1ns/100ps
`default_nettype none

module dfpa_pick
   import dfpa_pkg::*;
#(
   parameter int SOURCES = 7
) (
   input wire logic [SOURCES-1:0] pending,
   input wire logic [SOURCES*3-1:0] codes,
   output dfpa_grant_s pick
);

   always_comb begin
      logic [2:0] best;
      logic [2:0] code;
      best = 3'h0;
      code = 3'h0;
      pick = '{index: 3'h0, valid: 1'b0};
      for (int i = 0; i < SOURCES; i++) begin
         code = codes[i*3 +: 3];
         // Strict less-than keeps the earlier source on equal codes.
         if (pending[i] && code != 3'h0 && (!pick.valid || code < best)) begin
            best = code;
            pick.index = 3'(i);
            pick.valid = 1'b1;
         end
      end
   end

endmodule : dfpa_pick
`default_nettype wire

// >>> sim/dfpa_mem_model.sv
// Behavioural frame buffer memory controller that ends each grant after a set number of cycles.
`timescale 1ns/100ps
`default_nettype none

module dfpa_mem_model
   import dfpa_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic grant_valid,
   input wire logic [7:0] hold_cycles,
   output logic xfer_done
);
   // ==========================================================
   // Transfer length
   logic [7:0] busy_count;

   // The done pulse is one cycle long; a longer one would end the next grant too early.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy_count <= 8'h00;
         xfer_done <= 1'b0;
      end else begin
         busy_count <= grant_valid ? busy_count + 8'h01 : 8'h00;
         xfer_done <= grant_valid && !xfer_done && (busy_count == hold_cycles);
      end
   end
endmodule : dfpa_mem_model

`default_nettype wire

// >>> sim/display_fifo_priority_arbiter_tb.sv
// Self-checking testbench of the display FIFO priority arbiter.
`timescale 1ns/100ps
`default_nettype none

module display_fifo_priority_arbiter_tb
   import dfpa_pkg::*;
;
   // ==========================================================
   // Signals
   logic aclk, aresetn;
   logic [7:0] awaddr, araddr, hold_cycles;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rsp;
   logic [4:0] graphics_empty, video_one_empty, video_two_empty;
   logic pr1_req, pw_req, cap_req, pr2_req, xfer_done, grant_valid;
   logic [6:0] grant;
   int miscompares = 0;
   int cmp_count = 0;
   int cycles = 0;

   dfpa_arbiter dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .graphics_empty(graphics_empty), .video_one_empty(video_one_empty),
      .video_two_empty(video_two_empty), .panel_read_one_req(pr1_req), .panel_write_req(pw_req),
      .capture_req(cap_req), .panel_read_two_req(pr2_req), .xfer_done(xfer_done),
      .grant(grant), .grant_valid(grant_valid));

   dfpa_mem_model mem_u (.aclk(aclk), .aresetn(aresetn), .grant_valid(grant_valid),
      .hold_cycles(hold_cycles), .xfer_done(xfer_done));

   // ==========================================================
   // Clock, reset and timeout
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         complete_run();
      end
   end

   // ==========================================================
   // Tasks
   task automatic complete_run();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // Address and data are offered together and released each on its own handshake.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r, input logic [3:0] s = 4'hF);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_rd

   task automatic set_pend(input logic [6:0] p);
      @(posedge aclk);
      graphics_empty <= p[0] ? 5'h06 : 5'h00;
      pr1_req <= p[1];
      video_one_empty <= p[2] ? 5'h06 : 5'h00;
      video_two_empty <= p[3] ? 5'h06 : 5'h00;
      pw_req <= p[4];
      cap_req <= p[5];
      pr2_req <= p[6];
   endtask : set_pend

   task automatic expect_grant(input logic [6:0] exp);
      do @(posedge aclk); while (grant_valid !== 1'b1);
      chk({25'h0, grant}, {25'h0, exp}, "grant");
   endtask : expect_grant

   // Drops every request, then waits for the memory model to end the standing grant.
   task automatic finish_grant();
      set_pend(7'h00);
      do @(posedge aclk); while (grant_valid !== 1'b0);
   endtask : finish_grant

   task automatic no_grant();
      repeat (12) @(posedge aclk);
      chk({31'h0, grant_valid}, 32'h0, "grant_valid");
   endtask : no_grant

   // ==========================================================
   // Main sequence
   initial begin
      aresetn = 1'b0;
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {graphics_empty, video_one_empty, video_two_empty} = '0;
      {pr1_req, pw_req, cap_req, pr2_req} = '0;
      hold_cycles = 8'h02;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(8'h54, rd, rsp);
      chk(rd, 32'h07216543, "rank reset");
      chk({30'h0, rsp}, 32'h0, "rank resp");
      axi_rd(8'h58, rd, rsp);
      chk(rd, 32'h00000444, "level reset");
      axi_rd(8'h60, rd, rsp);
      chk({rd[29:0], rsp}, 32'h2, "unmapped read");
      axi_wr(8'h60, 32'hFFFFFFFF, rsp);
      chk({30'h0, rsp}, 32'h2, "unmapped write");
      axi_wr(8'h54, 32'hFFFFFFFF, rsp);
      axi_rd(8'h54, rd, rsp);
      chk(rd, 32'h07777777, "reserved bits");
      axi_wr(8'h54, 32'h00000000, rsp, 4'h2);
      axi_rd(8'h54, rd, rsp);
      chk(rd, 32'h07770077, "byte strobe");
      axi_wr(8'h5C, 32'h00000000, rsp);
      chk({30'h0, rsp}, 32'h2, "status write");
      axi_wr(8'h54, 32'h07216543, rsp);
      set_pend(7'h7F);
      expect_grant(7'h10);
      finish_grant();
      for (int i = 0; i < 7; i++) begin
         axi_wr(8'h54, (32'h07777777 & ~(32'h7 << (4 * i))) | (32'h1 << (4 * i)), rsp);
         set_pend(7'h7F);
         expect_grant(7'h01 << i);
         finish_grant();
      end
      axi_wr(8'h54, 32'h03333333, rsp);
      set_pend(7'h7F);
      expect_grant(7'h01);
      finish_grant();
      axi_wr(8'h54, 32'h03333330, rsp);
      set_pend(7'h7F);
      expect_grant(7'h02);
      finish_grant();
      axi_wr(8'h54, 32'h00000000, rsp);
      set_pend(7'h7F);
      no_grant();
      finish_grant();
      axi_wr(8'h54, 32'h07216543, rsp);
      graphics_empty <= 5'h05;
      no_grant();
      graphics_empty <= 5'h06;
      expect_grant(7'h01);
      finish_grant();
      axi_wr(8'h58, 32'h00000447, rsp);
      graphics_empty <= 5'h0B;
      no_grant();
      graphics_empty <= 5'h0C;
      expect_grant(7'h01);
      finish_grant();
      axi_wr(8'h58, 32'h00000444, rsp);
      hold_cycles <= 8'h1E;
      set_pend(7'h7F);
      expect_grant(7'h10);
      axi_wr(8'h54, 32'h07776541, rsp);
      axi_rd(8'h5C, rd, rsp);
      chk(rd, 32'h000004FF, "status");
      chk({25'h0, grant}, 32'h10, "grant kept");
      do @(posedge aclk); while (grant_valid !== 1'b0);
      expect_grant(7'h01);
      finish_grant();
      complete_run();
   end
endmodule : display_fifo_priority_arbiter_tb

`default_nettype wire
